// *** verilog/msb_pkg.sv ***
// package for the motor setup word and digital noise-mask timer
// assumes one 40 MHz clock and a synchronous power-on reset
`default_nettype none
package msb_pkg;

  // ==========================================================
  // setup word layout
  localparam int unsigned SETUP_W        = 16;
  localparam int unsigned PAIRING_LSB    = 0;
  localparam int unsigned PAIRING_W      = 3;
  localparam int unsigned MASK1_LSB      = 3;
  localparam int unsigned MASK2_LSB      = 5;
  localparam int unsigned MASK_W         = 2;
  localparam int unsigned CONV_A_BIT     = 7;
  localparam int unsigned CONV_B_BIT     = 8;
  localparam int unsigned CONV_C_BIT     = 9;
  localparam int unsigned GAIN1_BIT      = 10;
  localparam int unsigned GAIN2_BIT      = 11;
  localparam int unsigned TEST_LSB       = 12;
  localparam int unsigned TEST_W         = 3;
  localparam int unsigned SPARE_BIT      = 15;

  // ==========================================================
  // reset values
  localparam logic [2:0] PAIRING_RST     = 3'h0;
  localparam logic [1:0] MASK_RST        = 2'h0;
  localparam logic       GAIN_RST        = 1'b0;
  localparam logic [2:0] TEST_RST        = 3'h0;
  localparam logic       SPARE_RST       = 1'b0;

  // ==========================================================
  // motor pairing codes
  localparam logic [2:0] PAIR_STEP_STEP  = 3'h0;
  localparam logic [2:0] PAIR_STEP_LRG   = 3'h1;
  localparam logic [2:0] PAIR_STEP_SML2  = 3'h2;
  localparam logic [2:0] PAIR_LRG_SML2   = 3'h3;
  localparam logic [2:0] PAIR_LRG_LRG    = 3'h4;
  localparam logic [2:0] PAIR_SML4       = 3'h5;

  // ==========================================================
  // mask lengths in oscillator periods
  localparam logic [2:0] MASK_LEN_00     = 3'h5;
  localparam logic [2:0] MASK_LEN_01     = 3'h2;
  localparam logic [2:0] MASK_LEN_10     = 3'h3;
  localparam logic [2:0] MASK_LEN_11     = 3'h4;
  localparam logic [2:0] PROC_PERIODS    = 3'h1;
  localparam int unsigned CNT_W          = 3;

  // ==========================================================
  // timer states
  typedef enum logic [2:0] {
    MT_IDLE  = 3'b001,
    MT_SYNC  = 3'b010,
    MT_COUNT = 3'b100
  } msb_mask_state_t;

endpackage : msb_pkg
`default_nettype wire

// *** verilog/msb_sync3.sv ***
// three-stage synchroniser for pin inputs
// a change is accepted once the second and third stages agree
`default_nettype none
module msb_sync3
  import msb_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] val_d;
  logic [WIDTH-1:0] val_q;

  // ==========================================================
  // stage chain, free running so pin levels are ready at reset
  always_ff @(posedge clk_i) begin
    s1_q <= async_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_comb begin
    val_d = val_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        val_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      val_q <= s3_q;
    end else begin
      val_q <= val_d;
    end
  end

  assign sync_o = val_q;

endmodule : msb_sync3
`default_nettype wire

// *** verilog/msb_mask_timer.sv ***
// digital noise-mask timer for one channel pair
// assumes osc_tick_i pulses once per main chop oscillator period
`default_nettype none
module msb_mask_timer
  import msb_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             osc_tick_i,
  input  wire logic             phase_chg_i,
  input  wire logic             charge_start_i,
  input  wire logic             dc_mode_i,
  input  wire logic [CNT_W-1:0] mask_len_i,
  output var  logic             mask_o
);

  msb_mask_state_t  state_d;
  msb_mask_state_t  state_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_q;
  logic             mask_d;
  logic             mask_q;

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      MT_IDLE: begin
      end
      MT_SYNC: begin
        if (osc_tick_i) begin
          state_d = MT_COUNT;
        end
      end
      MT_COUNT: begin
        if (osc_tick_i) begin
          if (cnt_q <= 3'h1) begin
            state_d = MT_IDLE;
          end else begin
            cnt_d = cnt_q - 3'h1;
          end
        end
      end
      default: begin
        state_d = MT_IDLE;
      end
    endcase
    if (charge_start_i) begin
      state_d = MT_COUNT;
      cnt_d   = mask_len_i;
    end
    if (phase_chg_i) begin
      state_d = MT_SYNC;
      cnt_d   = CNT_W'(mask_len_i + PROC_PERIODS);
    end
    if (!dc_mode_i) begin
      state_d = MT_IDLE;
    end
    mask_d = (state_d != MT_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= MT_IDLE;
      cnt_q   <= '0;
      mask_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      mask_q  <= mask_d;
    end
  end

  assign mask_o = mask_q;

endmodule : msb_mask_timer
`default_nettype wire

// *** verilog/msb_top.sv ***
// initial setup word latch and digital noise-mask control
// assumes the serial shifter presents the shifted word on SHIFT_WORD_I
`default_nettype none
module msb_top
  import msb_pkg::*;
(
  input  wire logic               CLK_I,
  input  wire logic               SRST_I,
  input  wire logic               WAKE_I,
  input  wire logic               STROBE_I,
  input  wire logic               DATA_I,
  input  wire logic [SETUP_W-1:0] SHIFT_WORD_I,
  input  wire logic               CONV_DEFAULT_I,
  input  wire logic               MAIN_CHOP_OSCILLATOR_I,
  input  wire logic               PHASE1_I,
  input  wire logic               PHASE2_I,
  input  wire logic               CHARGE_START1_I,
  input  wire logic               CHARGE_START2_I,
  input  wire logic               CUR_LIMIT1_I,
  input  wire logic               CUR_LIMIT2_I,
  output logic [PAIRING_W-1:0]    MOTOR_PAIRING_O,
  output logic [MASK_W-1:0]       MASK_LEN_PAIR1_O,
  output logic [MASK_W-1:0]       MASK_LEN_PAIR2_O,
  output logic                    CONVERTER_A_OFF_O,
  output logic                    CONVERTER_B_OFF_O,
  output logic                    CONVERTER_C_OFF_O,
  output logic                    VREF_GAIN1_O,
  output logic                    VREF_GAIN2_O,
  output logic [TEST_W-1:0]       TEST_MODE_O,
  output logic                    EXT_SETUP_LOAD_O,
  output logic                    DC_MODE1_O,
  output logic                    DC_MODE2_O,
  output logic                    FAST_DECAY1_O,
  output logic                    FAST_DECAY2_O,
  output logic                    NOISE_MASK1_O,
  output logic                    NOISE_MASK2_O,
  output logic                    CUR_LIMIT1_O,
  output logic                    CUR_LIMIT2_O
);

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] mask_len(input logic [MASK_W-1:0] f);
    case (f)
      2'h0:    mask_len = MASK_LEN_00;
      2'h1:    mask_len = MASK_LEN_01;
      2'h2:    mask_len = MASK_LEN_10;
      default: mask_len = MASK_LEN_11;
    endcase
  endfunction : mask_len

  // pair one is stepper in codes 0..2, pair two only in code 0;
  // unlisted codes keep both pairs as steppers
  function automatic logic pair_is_dc(input logic [PAIRING_W-1:0] c,
                                      input logic                 second);
    case (c)
      PAIR_STEP_STEP: pair_is_dc = 1'b0;
      PAIR_STEP_LRG:  pair_is_dc = second;
      PAIR_STEP_SML2: pair_is_dc = second;
      PAIR_LRG_SML2:  pair_is_dc = 1'b1;
      PAIR_LRG_LRG:   pair_is_dc = 1'b1;
      PAIR_SML4:      pair_is_dc = 1'b1;
      default:        pair_is_dc = 1'b0;
    endcase
  endfunction : pair_is_dc

  // ==========================================================
  // pin synchronisers
  logic [8:0] pins_async;
  logic [8:0] pins_sync;
  logic       wake_s;
  logic       strobe_s;
  logic       data_s;
  logic       conv_def_s;
  logic       osc_s;
  logic       phase1_s;
  logic       phase2_s;
  logic       lim1_s;
  logic       lim2_s;

  assign pins_async = {CUR_LIMIT2_I, CUR_LIMIT1_I, PHASE2_I, PHASE1_I,
                       MAIN_CHOP_OSCILLATOR_I, CONV_DEFAULT_I, DATA_I,
                       STROBE_I, WAKE_I};

  msb_sync3 #(
    .WIDTH (9)
  ) u_sync (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .async_i (pins_async),
    .sync_o  (pins_sync)
  );

  assign wake_s     = pins_sync[0];
  assign strobe_s   = pins_sync[1];
  assign data_s     = pins_sync[2];
  assign conv_def_s = pins_sync[3];
  assign osc_s      = pins_sync[4];
  assign phase1_s   = pins_sync[5];
  assign phase2_s   = pins_sync[6];
  assign lim1_s     = pins_sync[7];
  assign lim2_s     = pins_sync[8];

  // ==========================================================
  // edge detection
  logic strobe_prev_q;
  logic osc_prev_q;
  logic phase1_prev_q;
  logic phase2_prev_q;
  logic strobe_rise;
  logic osc_tick;
  logic phase1_chg;
  logic phase2_chg;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      // track pin levels in reset: no false edge after release
      strobe_prev_q <= strobe_s;
      osc_prev_q    <= osc_s;
      phase1_prev_q <= phase1_s;
      phase2_prev_q <= phase2_s;
    end else begin
      strobe_prev_q <= strobe_s;
      osc_prev_q    <= osc_s;
      phase1_prev_q <= phase1_s;
      phase2_prev_q <= phase2_s;
    end
  end

  assign strobe_rise = strobe_s & ~strobe_prev_q;
  assign osc_tick    = osc_s & ~osc_prev_q;
  assign phase1_chg  = phase1_s ^ phase1_prev_q;
  assign phase2_chg  = phase2_s ^ phase2_prev_q;

  // ==========================================================
  // setup word register
  logic [PAIRING_W-1:0] pairing_d;
  logic [PAIRING_W-1:0] pairing_q;
  logic [MASK_W-1:0]    mask1_d;
  logic [MASK_W-1:0]    mask1_q;
  logic [MASK_W-1:0]    mask2_d;
  logic [MASK_W-1:0]    mask2_q;
  logic [2:0]           conv_off_d;
  logic [2:0]           conv_off_q;
  logic                 gain1_d;
  logic                 gain1_q;
  logic                 gain2_d;
  logic                 gain2_q;
  logic [TEST_W-1:0]    test_d;
  logic [TEST_W-1:0]    test_q;
  logic                 spare_d;
  logic                 spare_q;
  logic                 ext_load_d;
  logic                 ext_load_q;
  logic                 setup_load;

  // strobe rise while asleep: data low selects the initial word
  assign setup_load = strobe_rise & ~wake_s & ~data_s;

  always_comb begin
    pairing_d  = pairing_q;
    mask1_d    = mask1_q;
    mask2_d    = mask2_q;
    conv_off_d = conv_off_q;
    gain1_d    = gain1_q;
    gain2_d    = gain2_q;
    test_d     = test_q;
    spare_d    = spare_q;
    ext_load_d = strobe_rise & ~wake_s & data_s;
    if (setup_load) begin
      pairing_d  = SHIFT_WORD_I[PAIRING_LSB +: PAIRING_W];
      mask1_d    = SHIFT_WORD_I[MASK1_LSB +: MASK_W];
      mask2_d    = SHIFT_WORD_I[MASK2_LSB +: MASK_W];
      conv_off_d = {SHIFT_WORD_I[CONV_C_BIT], SHIFT_WORD_I[CONV_B_BIT],
                    SHIFT_WORD_I[CONV_A_BIT]};
      gain1_d    = SHIFT_WORD_I[GAIN1_BIT];
      gain2_d    = SHIFT_WORD_I[GAIN2_BIT];
      test_d     = SHIFT_WORD_I[TEST_LSB +: TEST_W];
      spare_d    = SHIFT_WORD_I[SPARE_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pairing_q  <= PAIRING_RST;
      mask1_q    <= MASK_RST;
      mask2_q    <= MASK_RST;
      conv_off_q <= {3{conv_def_s}};
      gain1_q    <= GAIN_RST;
      gain2_q    <= GAIN_RST;
      test_q     <= TEST_RST;
      spare_q    <= SPARE_RST;
      ext_load_q <= 1'b0;
    end else begin
      pairing_q  <= pairing_d;
      mask1_q    <= mask1_d;
      mask2_q    <= mask2_d;
      conv_off_q <= conv_off_d;
      gain1_q    <= gain1_d;
      gain2_q    <= gain2_d;
      test_q     <= test_d;
      spare_q    <= spare_d;
      ext_load_q <= ext_load_d;
    end
  end

  // ==========================================================
  // pair modes
  logic dc1_d;
  logic dc1_q;
  logic dc2_d;
  logic dc2_q;

  always_comb begin
    dc1_d = pair_is_dc(pairing_q, 1'b0);
    dc2_d = pair_is_dc(pairing_q, 1'b1);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      dc1_q <= 1'b0;
      dc2_q <= 1'b0;
    end else begin
      dc1_q <= dc1_d;
      dc2_q <= dc2_d;
    end
  end

  // ==========================================================
  // noise-mask timers
  logic mask1_act;
  logic mask2_act;

  msb_mask_timer u_mask1 (
    .clk_i          (CLK_I),
    .srst_i         (SRST_I),
    .osc_tick_i     (osc_tick),
    .phase_chg_i    (phase1_chg),
    .charge_start_i (CHARGE_START1_I),
    .dc_mode_i      (dc1_q),
    .mask_len_i     (mask_len(mask1_q)),
    .mask_o         (mask1_act)
  );

  msb_mask_timer u_mask2 (
    .clk_i          (CLK_I),
    .srst_i         (SRST_I),
    .osc_tick_i     (osc_tick),
    .phase_chg_i    (phase2_chg),
    .charge_start_i (CHARGE_START2_I),
    .dc_mode_i      (dc2_q),
    .mask_len_i     (mask_len(mask2_q)),
    .mask_o         (mask2_act)
  );

  // ==========================================================
  // comparator gating
  logic lim1_d;
  logic lim1_q;
  logic lim2_d;
  logic lim2_q;

  always_comb begin
    lim1_d = lim1_s & ~mask1_act;
    lim2_d = lim2_s & ~mask2_act;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      lim1_q <= 1'b0;
      lim2_q <= 1'b0;
    end else begin
      lim1_q <= lim1_d;
      lim2_q <= lim2_d;
    end
  end

  // ==========================================================
  // outputs
  assign MOTOR_PAIRING_O   = pairing_q;
  assign MASK_LEN_PAIR1_O  = mask1_q;
  assign MASK_LEN_PAIR2_O  = mask2_q;
  assign CONVERTER_A_OFF_O = conv_off_q[0];
  assign CONVERTER_B_OFF_O = conv_off_q[1];
  assign CONVERTER_C_OFF_O = conv_off_q[2];
  assign VREF_GAIN1_O      = gain1_q;
  assign VREF_GAIN2_O      = gain2_q;
  assign TEST_MODE_O       = test_q;
  assign EXT_SETUP_LOAD_O  = ext_load_q;
  assign DC_MODE1_O        = dc1_q;
  assign DC_MODE2_O        = dc2_q;
  assign FAST_DECAY1_O     = dc1_q;
  assign FAST_DECAY2_O     = dc2_q;
  assign NOISE_MASK1_O     = mask1_act;
  assign NOISE_MASK2_O     = mask2_act;
  assign CUR_LIMIT1_O      = lim1_q;
  assign CUR_LIMIT2_O      = lim2_q;

endmodule : msb_top
`default_nettype wire

// *** verif/msb_top_props.sv ***
// assertions on the setup latch and noise-mask outputs
// assumes binding into msb_top, one clock, sync reset
`default_nettype none
module msb_top_props
  import msb_pkg::*;
(
  input wire logic                 CLK_I,
  input wire logic                 SRST_I,
  input wire logic                 WAKE_I,
  input wire logic                 DATA_I,
  input wire logic                 CONV_DEFAULT_I,
  input wire logic                 CHARGE_START1_I,
  input wire logic [PAIRING_W-1:0] MOTOR_PAIRING_O,
  input wire logic [MASK_W-1:0]    MASK_LEN_PAIR1_O,
  input wire logic [MASK_W-1:0]    MASK_LEN_PAIR2_O,
  input wire logic                 CONVERTER_A_OFF_O,
  input wire logic                 CONVERTER_B_OFF_O,
  input wire logic                 CONVERTER_C_OFF_O,
  input wire logic                 VREF_GAIN1_O,
  input wire logic                 VREF_GAIN2_O,
  input wire logic [TEST_W-1:0]    TEST_MODE_O,
  input wire logic                 EXT_SETUP_LOAD_O,
  input wire logic                 DC_MODE1_O,
  input wire logic                 DC_MODE2_O,
  input wire logic                 FAST_DECAY1_O,
  input wire logic                 FAST_DECAY2_O,
  input wire logic                 NOISE_MASK1_O,
  input wire logic                 CUR_LIMIT1_O
);
  // ==========================================
  // sequences
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire logic [SETUP_W-2:0] fields = {TEST_MODE_O, VREF_GAIN2_O, VREF_GAIN1_O,
    CONVERTER_C_OFF_O, CONVERTER_B_OFF_O, CONVERTER_A_OFF_O, MASK_LEN_PAIR2_O,
    MASK_LEN_PAIR1_O, MOTOR_PAIRING_O};
  sequence s_charge;
    CHARGE_START1_I && DC_MODE1_O;
  endsequence
  sequence s_held_reset;
    SRST_I [*6];
  endsequence

  // ==========================================
  // checks
  a_load_needs_sleep: assert property (
    !$stable(fields) |-> !$past(WAKE_I, 4) && !$past(DATA_I, 4))
    else $error("setup fields changed without a sleep-mode initial write");
  a_ext_pulse_only: assert property (
    EXT_SETUP_LOAD_O |-> $stable(fields) && $past(DATA_I, 4) ##1 !EXT_SETUP_LOAD_O)
    else $error("extended strobe pulse wrong");
  a_dc_mode_map: assert property (
    1'b1 |=> DC_MODE1_O == ($past(MOTOR_PAIRING_O) inside {3'h3, 3'h4, 3'h5})
      && DC_MODE2_O == ($past(MOTOR_PAIRING_O) inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}))
    else $error("dc mode does not follow pairing");
  a_decay_is_fast: assert property (
    FAST_DECAY1_O == DC_MODE1_O && FAST_DECAY2_O == DC_MODE2_O)
    else $error("fast decay differs from dc mode");
  a_stepper_no_mask: assert property (
    !DC_MODE1_O ##1 !DC_MODE1_O |-> !NOISE_MASK1_O)
    else $error("mask active on stepper pair");
  a_charge_masks: assert property (
    s_charge |=> NOISE_MASK1_O)
    else $error("charge start did not raise mask");
  a_mask_gates_limit: assert property (
    NOISE_MASK1_O ##1 NOISE_MASK1_O |-> !CUR_LIMIT1_O)
    else $error("comparator passed during mask");
  a_reset_defaults: assert property (disable iff (1'b0)
    s_held_reset |=> {TEST_MODE_O, VREF_GAIN2_O, VREF_GAIN1_O, MASK_LEN_PAIR2_O,
      MASK_LEN_PAIR1_O, MOTOR_PAIRING_O} == 12'h000 && !NOISE_MASK1_O
      && {CONVERTER_C_OFF_O, CONVERTER_B_OFF_O, CONVERTER_A_OFF_O} == {3{CONV_DEFAULT_I}})
    else $error("setup defaults wrong after reset");
endmodule : msb_top_props

bind msb_top msb_top_props u_props (.CLK_I(CLK_I), .SRST_I(SRST_I), .WAKE_I(WAKE_I),
  .DATA_I(DATA_I), .CONV_DEFAULT_I(CONV_DEFAULT_I), .CHARGE_START1_I(CHARGE_START1_I),
  .MOTOR_PAIRING_O(MOTOR_PAIRING_O), .MASK_LEN_PAIR1_O(MASK_LEN_PAIR1_O),
  .MASK_LEN_PAIR2_O(MASK_LEN_PAIR2_O), .CONVERTER_A_OFF_O(CONVERTER_A_OFF_O),
  .CONVERTER_B_OFF_O(CONVERTER_B_OFF_O), .CONVERTER_C_OFF_O(CONVERTER_C_OFF_O),
  .VREF_GAIN1_O(VREF_GAIN1_O), .VREF_GAIN2_O(VREF_GAIN2_O), .TEST_MODE_O(TEST_MODE_O),
  .EXT_SETUP_LOAD_O(EXT_SETUP_LOAD_O), .DC_MODE1_O(DC_MODE1_O), .DC_MODE2_O(DC_MODE2_O),
  .FAST_DECAY1_O(FAST_DECAY1_O), .FAST_DECAY2_O(FAST_DECAY2_O),
  .NOISE_MASK1_O(NOISE_MASK1_O), .CUR_LIMIT1_O(CUR_LIMIT1_O));
`default_nettype wire

// *** verif/msb_host_model.sv ***
// host controller model for the setup pins
// assumes the same clock as the block; strobe idles low
`default_nettype none
module msb_host_model
  import msb_pkg::*;
(
  input  wire logic               clk_i,
  output var  logic               wake_o,
  output var  logic               strobe_o,
  output var  logic               data_o,
  output var  logic [SETUP_W-1:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wake_o, strobe_o, data_o, word_o} = {1'b0, 1'b0, 1'b1, 16'hffff};
  end
  // ==========================================
  // one strobed word; levels held past the edge
  task automatic write_word(input logic wake, input logic ext, input logic [15:0] w);
    @(posedge clk_i);
    wake_o <= wake;
    data_o <= ext;
    word_o <= w & 16'h0fff;
    repeat (5) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    strobe_o <= 1'b0;
    data_o <= ~ext;
    word_o <= ~w;
    repeat (5) @(posedge clk_i);
  endtask : write_word
endmodule : msb_host_model
`default_nettype wire

// *** verif/msb_top_tb.sv ***
// testbench for the setup latch and noise-mask timer
// assumes the host model drives the setup pins; osc made from clk
`default_nettype none
module msb_top_tb
  import msb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, srst, conv_def, wake, strobe, data;
  logic               osc = 1'b0;
  logic               ca_o, cb_o, cc_o, g1_o, g2_o, ext_o;
  logic [1:0]         phase, cs, cl, len1_o, len2_o;
  wire logic [1:0]    dc_o, fd_o, m, lim;
  logic [2:0]         ph = 3'h0;
  logic [2:0]         pairing_o, test_o;
  logic [15:0]        word, w;
  int                 fail_count, comparisons;
  int                 ext_n = 0;
  int                 lens [4] = '{5, 2, 3, 4};
  wire logic [15:0]   setup = {1'b0, test_o, g2_o, g1_o, cc_o, cb_o, ca_o, len2_o,
    len1_o, pairing_o};

  msb_host_model host (.clk_i(clk), .wake_o(wake), .strobe_o(strobe), .data_o(data),
    .word_o(word));
  msb_top uut (.CLK_I(clk), .SRST_I(srst), .WAKE_I(wake), .STROBE_I(strobe),
    .DATA_I(data), .SHIFT_WORD_I(word), .CONV_DEFAULT_I(conv_def),
    .MAIN_CHOP_OSCILLATOR_I(osc), .PHASE1_I(phase[0]), .PHASE2_I(phase[1]),
    .CHARGE_START1_I(cs[0]), .CHARGE_START2_I(cs[1]), .CUR_LIMIT1_I(cl[0]),
    .CUR_LIMIT2_I(cl[1]), .MOTOR_PAIRING_O(pairing_o), .MASK_LEN_PAIR1_O(len1_o),
    .MASK_LEN_PAIR2_O(len2_o), .CONVERTER_A_OFF_O(ca_o), .CONVERTER_B_OFF_O(cb_o),
    .CONVERTER_C_OFF_O(cc_o), .VREF_GAIN1_O(g1_o), .VREF_GAIN2_O(g2_o),
    .TEST_MODE_O(test_o), .EXT_SETUP_LOAD_O(ext_o), .DC_MODE1_O(dc_o[0]),
    .DC_MODE2_O(dc_o[1]), .FAST_DECAY1_O(fd_o[0]), .FAST_DECAY2_O(fd_o[1]),
    .NOISE_MASK1_O(m[0]), .NOISE_MASK2_O(m[1]), .CUR_LIMIT1_O(lim[0]),
    .CUR_LIMIT2_O(lim[1]));

  // ==========================================
  // clock, chop oscillator of eight clocks
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    osc <= (ph < 3'h4);
    if (ext_o === 1'b1) ext_n <= ext_n + 1;
  end

  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic do_reset(input logic cd);
    conv_def <= cd;
    repeat (5) @(posedge clk);
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(setup, {6'h00, {3{cd}}, 7'h00});
    check(16'({dc_o, fd_o, m}), 16'h0000);
  endtask : do_reset

  // mask length in whole osc periods, event at a fixed osc phase
  task automatic measure(input int p, input logic k, input int n);
    int d = 0;
    do @(posedge clk); while (ph != (k ? 3'h5 : 3'h7));
    if (k) phase[p] <= ~phase[p];
    else cs[p] <= 1'b1;
    @(posedge clk);
    cs[p] <= 1'b0;
    for (int i = 0; i < 90 && (d == 0 || m[p]); i++) begin
      @(posedge clk);
      if (m[p] === 1'b1) d++;
    end
    check(16'((d + 7) / 8), 16'(k ? n + 2 : n));
    repeat (2) @(posedge clk);
    check(16'(lim[p]), 16'h0001);
  endtask : measure

  task automatic no_mask(input int p);
    logic s = 1'b0;
    phase[p] <= ~phase[p];
    cs[p] <= 1'b1;
    @(posedge clk);
    cs[p] <= 1'b0;
    repeat (60) begin
      @(posedge clk);
      s |= m[p];
    end
    check(16'(s), 16'h0000);
  endtask : no_mask

  // ==========================================
  // tests
  initial begin
    {srst, conv_def, phase, cs, cl} = {1'b1, 1'b1, 6'h03};
    {fail_count, comparisons} = {32'd0, 32'd0};
    do_reset(1'b1);
    for (int c = 0; c < 6; c++) begin
      w = {4'h0, c[1:0], c[2:0], ~c[1:0], c[1:0], c[2:0]};
      host.write_word(1'b0, 1'b0, w);
      check(setup, w);
      check(16'({dc_o, fd_o}), 16'({c > 0, c > 2, c > 0, c > 2}));
    end
    host.write_word(1'b1, 1'b0, 16'h0aaa);
    check(setup, w);
    host.write_word(1'b0, 1'b1, 16'h0aaa);
    check(setup, w);
    check(16'(ext_n), 16'h0001);
    for (int f = 0; f < 4; f++) begin
      host.write_word(1'b0, 1'b0, {9'h000, f[1:0], f[1:0], PAIR_LRG_LRG});
      for (int p = 0; p < 2; p++) begin
        measure(p, 1'b0, lens[f]);
        measure(p, 1'b1, lens[f]);
      end
    end
    host.write_word(1'b0, 1'b0, {13'h0000, PAIR_STEP_LRG});
    no_mask(0);
    measure(1, 1'b1, lens[0]);
    cl <= 2'h0;
    repeat (8) @(posedge clk);
    check(16'(lim), 16'h0000);
    do_reset(1'b0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : msb_top_tb
`default_nettype wire
